// File: otss_pkg.sv
// Package: constants for the output terminal status selector
// Operation
// - Code 23: on at zero frequency or stopped
// - Code 24: on when power-on time exceeds threshold
// - Code 30: on when enabled timer reaches setting
// - Code 31: on when analog input out of limits
// - Code 32: on while load loss detected
// - Code 33: on while running in reverse
// - Code 35: on when heatsink reaches threshold
// - Code 37: on at lower limit or stopped
// - Code 38: on at fault with continue-run handling
// - Code 40: on when run time exceeds threshold
// - Code 20: output follows host-written value
`default_nettype none
package otss_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned FUNC_W = 6;
   // Register word offsets (byte address = 4 * index)
   localparam logic [ADDR_W-1:0] REG_FUNC     = 4'h0;
   localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h1;
   localparam logic [ADDR_W-1:0] REG_PON_THR  = 4'h2;
   localparam logic [ADDR_W-1:0] REG_TMR_SET  = 4'h3;
   localparam logic [ADDR_W-1:0] REG_RUN_THR  = 4'h4;
   localparam logic [ADDR_W-1:0] REG_AIN_LIM  = 4'h5;
   localparam logic [ADDR_W-1:0] REG_TEMP_THR = 4'h6;
   localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h7;
   localparam logic [ADDR_W-1:0] REG_IRQ_STS  = 4'h8;
   localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 4'h9;
   localparam logic [ADDR_W-1:0] REG_IRQ_CLR  = 4'hA;
   // Control and analog limit fields
   localparam int unsigned CTRL_HOST_BIT  = 0;
   localparam int unsigned CTRL_TMREN_BIT = 1;
   localparam int unsigned AIN_LO_LSB     = 0;
   localparam int unsigned AIN_HI_LSB     = 16;
   // Status / irq fields
   localparam int unsigned STS_OUT_BIT    = 0;
   localparam int unsigned IRQ_RISE_BIT   = 0;
   localparam int unsigned IRQ_FALL_BIT   = 1;
   localparam int unsigned IRQ_W          = 2;
   // Reset values
   localparam logic [FUNC_W-1:0] FUNC_RST = 6'h00;
   localparam logic [31:0]       ZERO32   = 32'h0000_0000;
   // Function codes
   localparam logic [FUNC_W-1:0] FC_HOST      = 6'd20;
   localparam logic [FUNC_W-1:0] FC_ZERO_SPD  = 6'd23;
   localparam logic [FUNC_W-1:0] FC_PON_TIME  = 6'd24;
   localparam logic [FUNC_W-1:0] FC_TIMING    = 6'd30;
   localparam logic [FUNC_W-1:0] FC_AIN_LIM   = 6'd31;
   localparam logic [FUNC_W-1:0] FC_LOAD_LOSS = 6'd32;
   localparam logic [FUNC_W-1:0] FC_REVERSE   = 6'd33;
   localparam logic [FUNC_W-1:0] FC_MOD_TEMP  = 6'd35;
   localparam logic [FUNC_W-1:0] FC_LOW_LIM   = 6'd37;
   localparam logic [FUNC_W-1:0] FC_WARNING   = 6'd38;
   localparam logic [FUNC_W-1:0] FC_RUN_TIME  = 6'd40;
   // Bus slave states
   typedef enum logic [2:0] {
      OTSS_IDLE = 3'b001,
      OTSS_ACK  = 3'b010,
      OTSS_DONE = 3'b100
   } otss_bus_st_type;
endpackage
`default_nettype wire

// File: otss_cond.sv
// Condition evaluator: one ON flag per supported function code
`default_nettype none
module otss_cond
   import otss_pkg::*;
#(
   parameter int unsigned VAL_W = 16
)(
   // Clock and reset
   input  wire logic             sys_clk_i,
   input  wire logic             resetn_i,
   // Drive state
   input  wire logic [VAL_W-1:0] out_freq_i,
   input  wire logic [VAL_W-1:0] low_lim_freq_i,
   input  wire logic             running_i,
   input  wire logic             reverse_i,
   input  wire logic             load_loss_i,
   input  wire logic             fault_i,
   input  wire logic             fault_continue_i,
   input  wire logic [31:0]      pon_time_i,
   input  wire logic [31:0]      run_time_i,
   input  wire logic [VAL_W-1:0] analog_input_one_i,
   input  wire logic [VAL_W-1:0] heatsink_temp_i,
   // Settings
   input  wire logic [31:0]      pon_thr_i,
   input  wire logic [31:0]      tmr_set_i,
   input  wire logic             tmr_en_i,
   input  wire logic [31:0]      run_thr_i,
   input  wire logic [VAL_W-1:0] ain_lo_i,
   input  wire logic [VAL_W-1:0] ain_hi_i,
   input  wire logic [VAL_W-1:0] temp_thr_i,
   // Condition flags, bit index = function code
   output logic [63:0]           cond_o
);
   import otss_pkg::*;

   typedef struct packed {
      logic [63:0] cond;
   } otss_cond_st_type;

   otss_cond_st_type s_q;
   otss_cond_st_type s_d;

   always_comb
   begin
      s_d = '0;
      s_d.cond[FC_ZERO_SPD]  = (out_freq_i == '0) || !running_i;
      s_d.cond[FC_PON_TIME]  = pon_time_i > pon_thr_i;
      s_d.cond[FC_TIMING]    = tmr_en_i && (run_time_i >= tmr_set_i);
      s_d.cond[FC_AIN_LIM]   = (analog_input_one_i > ain_hi_i) ||
                               (analog_input_one_i < ain_lo_i);
      s_d.cond[FC_LOAD_LOSS] = load_loss_i;
      s_d.cond[FC_REVERSE]   = running_i && reverse_i;
      s_d.cond[FC_MOD_TEMP]  = heatsink_temp_i >= temp_thr_i;
      s_d.cond[FC_LOW_LIM]   = !running_i || (out_freq_i <= low_lim_freq_i);
      s_d.cond[FC_WARNING]   = fault_i && fault_continue_i;
      s_d.cond[FC_RUN_TIME]  = run_time_i > run_thr_i;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign cond_o = s_q.cond;
endmodule
`default_nettype wire

// File: otss_sel.sv
// Function selector: picks one condition flag or the host value
`default_nettype none
module otss_sel
   import otss_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              resetn_i,
   // Selection
   input  wire logic [FUNC_W-1:0] func_i,
   input  wire logic [63:0]       cond_i,
   input  wire logic              host_val_i,
   // Terminal
   output logic                   term_o
);
   import otss_pkg::*;

   typedef struct packed {
      logic term;
   } otss_sel_st_type;

   otss_sel_st_type s_q;
   otss_sel_st_type s_d;

   always_comb
   begin
      s_d.term = 1'b0;
      case (func_i)
         FC_HOST:      s_d.term = host_val_i;
         FC_ZERO_SPD,
         FC_PON_TIME,
         FC_TIMING,
         FC_AIN_LIM,
         FC_LOAD_LOSS,
         FC_REVERSE,
         FC_MOD_TEMP,
         FC_LOW_LIM,
         FC_WARNING,
         FC_RUN_TIME:  s_d.term = cond_i[func_i];
         default:      s_d.term = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign term_o = s_q.term;

   property p_reserved_off;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (func_i == 6'd21 || func_i == 6'd22 || func_i == 6'd39) |=> !term_o;
   endproperty
   a_reserved_off: assert property (p_reserved_off) else $error("reserved code set output");

   property p_host_follow;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (func_i == FC_HOST) |=> (term_o == $past(host_val_i));
   endproperty
   a_host_follow: assert property (p_host_follow) else $error("output not following host");
endmodule
`default_nettype wire

// File: otss_top.sv
// Top: register slave, interrupts and output terminal selection
//
// Chosen here: the Avalon-MM register port and the register addresses.
`default_nettype none
module otss_top
   import otss_pkg::*;
#(
   parameter int unsigned VAL_W = 16
)(
   // Clock and reset
   input  wire logic                    sys_clk_i,
   input  wire logic                    resetn_i,
   // Avalon-MM slave
   input  wire logic [otss_pkg::ADDR_W-1:0] avs_address_i,
   input  wire logic                    avs_read_i,
   input  wire logic                    avs_write_i,
   input  wire logic [31:0]             avs_writedata_i,
   input  wire logic [3:0]              avs_byteenable_i,
   output logic [31:0]                  avs_readdata_o,
   output logic                         avs_waitrequest_o,
   // Drive state
   input  wire logic [VAL_W-1:0]        out_freq_i,
   input  wire logic [VAL_W-1:0]        low_lim_freq_i,
   input  wire logic                    running_i,
   input  wire logic                    reverse_i,
   input  wire logic                    load_loss_i,
   input  wire logic                    fault_i,
   input  wire logic                    fault_continue_i,
   input  wire logic [31:0]             pon_time_i,
   input  wire logic [31:0]             run_time_i,
   input  wire logic [VAL_W-1:0]        analog_input_one_i,
   input  wire logic [VAL_W-1:0]        heatsink_temp_i,
   // Terminal and interrupt
   output logic                         term_o,
   output logic                         irq_o
);
   import otss_pkg::*;

   typedef struct packed {
      otss_bus_st_type   st;
      logic [31:0]       rdata;
      logic [FUNC_W-1:0] func;
      logic              host_val;
      logic              tmr_en;
      logic [31:0]       pon_thr;
      logic [31:0]       tmr_set;
      logic [31:0]       run_thr;
      logic [VAL_W-1:0]  ain_lo;
      logic [VAL_W-1:0]  ain_hi;
      logic [VAL_W-1:0]  temp_thr;
      logic [IRQ_W-1:0]  irq_sts;
      logic [IRQ_W-1:0]  irq_en;
      logic              term_prev;
   } otss_top_st_type;

   otss_top_st_type s_q;
   otss_top_st_type s_d;
   logic [63:0]     cond;
   logic            term;

   ////////////////////////////////////////////////////////////////////////////
   // Condition and selector
   otss_cond #(.VAL_W(VAL_W)) u_cond (
      .sys_clk_i          (sys_clk_i),
      .resetn_i           (resetn_i),
      .out_freq_i         (out_freq_i),
      .low_lim_freq_i     (low_lim_freq_i),
      .running_i          (running_i),
      .reverse_i          (reverse_i),
      .load_loss_i        (load_loss_i),
      .fault_i            (fault_i),
      .fault_continue_i   (fault_continue_i),
      .pon_time_i         (pon_time_i),
      .run_time_i         (run_time_i),
      .analog_input_one_i (analog_input_one_i),
      .heatsink_temp_i    (heatsink_temp_i),
      .pon_thr_i          (s_q.pon_thr),
      .tmr_set_i          (s_q.tmr_set),
      .tmr_en_i           (s_q.tmr_en),
      .run_thr_i          (s_q.run_thr),
      .ain_lo_i           (s_q.ain_lo),
      .ain_hi_i           (s_q.ain_hi),
      .temp_thr_i         (s_q.temp_thr),
      .cond_o             (cond)
   );

   otss_sel u_sel (
      .sys_clk_i  (sys_clk_i),
      .resetn_i   (resetn_i),
      .func_i     (s_q.func),
      .cond_i     (cond),
      .host_val_i (s_q.host_val),
      .term_o     (term)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Register slave and interrupt logic
   always_comb
   begin
      logic [31:0]      wd;
      logic [IRQ_W-1:0] ev;
      logic [IRQ_W-1:0] clr;
      wd  = avs_writedata_i;
      s_d = s_q;
      clr = '0;
      ev  = '0;
      s_d.term_prev = term;
      ev[IRQ_RISE_BIT] = term && !s_q.term_prev;
      ev[IRQ_FALL_BIT] = !term && s_q.term_prev;
      case (s_q.st)
         OTSS_IDLE:
         begin
            if (avs_read_i || avs_write_i)
               s_d.st = OTSS_ACK;
            // Read word is captured here so it leaves a flip-flop in ACK
            if (avs_read_i)
            begin
               s_d.rdata = '0;
               if (avs_address_i == REG_FUNC)
                  s_d.rdata[FUNC_W-1:0] = s_q.func;
               else if (avs_address_i == REG_CTRL)
               begin
                  s_d.rdata[CTRL_HOST_BIT]  = s_q.host_val;
                  s_d.rdata[CTRL_TMREN_BIT] = s_q.tmr_en;
               end
               else if (avs_address_i == REG_PON_THR)
                  s_d.rdata = s_q.pon_thr;
               else if (avs_address_i == REG_TMR_SET)
                  s_d.rdata = s_q.tmr_set;
               else if (avs_address_i == REG_RUN_THR)
                  s_d.rdata = s_q.run_thr;
               else if (avs_address_i == REG_AIN_LIM)
               begin
                  s_d.rdata[AIN_LO_LSB +: VAL_W] = s_q.ain_lo;
                  s_d.rdata[AIN_HI_LSB +: VAL_W] = s_q.ain_hi;
               end
               else if (avs_address_i == REG_TEMP_THR)
                  s_d.rdata[VAL_W-1:0] = s_q.temp_thr;
               else if (avs_address_i == REG_STATUS)
                  s_d.rdata[STS_OUT_BIT] = term;
               else if (avs_address_i == REG_IRQ_STS)
                  s_d.rdata[IRQ_W-1:0] = s_q.irq_sts;
               else if (avs_address_i == REG_IRQ_EN)
                  s_d.rdata[IRQ_W-1:0] = s_q.irq_en;
            end
         end
         OTSS_ACK:
         begin
            s_d.st    = OTSS_DONE;
            s_d.rdata = '0;
            if (avs_write_i)
            begin
               if (avs_address_i == REG_FUNC)
                  s_d.func = wd[FUNC_W-1:0];
               else if (avs_address_i == REG_CTRL)
               begin
                  s_d.host_val = wd[CTRL_HOST_BIT];
                  s_d.tmr_en   = wd[CTRL_TMREN_BIT];
               end
               else if (avs_address_i == REG_PON_THR)
                  s_d.pon_thr = wd;
               else if (avs_address_i == REG_TMR_SET)
                  s_d.tmr_set = wd;
               else if (avs_address_i == REG_RUN_THR)
                  s_d.run_thr = wd;
               else if (avs_address_i == REG_AIN_LIM)
               begin
                  s_d.ain_lo = wd[AIN_LO_LSB +: VAL_W];
                  s_d.ain_hi = wd[AIN_HI_LSB +: VAL_W];
               end
               else if (avs_address_i == REG_TEMP_THR)
                  s_d.temp_thr = wd[VAL_W-1:0];
               else if (avs_address_i == REG_IRQ_EN)
                  s_d.irq_en = wd[IRQ_W-1:0];
               else if (avs_address_i == REG_IRQ_CLR)
                  clr = wd[IRQ_W-1:0];
            end
         end
         OTSS_DONE:
            s_d.st = OTSS_IDLE;
         default:
            s_d.st = OTSS_IDLE;
      endcase
      // Set wins over clear
      s_d.irq_sts = (s_q.irq_sts & ~clr) | ev;
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_q          <= '0;
         s_q.st       <= OTSS_IDLE;
         s_q.func     <= FUNC_RST;
         s_q.pon_thr  <= ZERO32;
         s_q.tmr_set  <= ZERO32;
         s_q.run_thr  <= ZERO32;
      end
      else
         s_q <= s_d;
   end

   // Answer in ACK state; read word already stands in its register
   assign avs_waitrequest_o = (s_q.st != OTSS_ACK);
   assign avs_readdata_o    = s_q.rdata;
   assign term_o            = term;
   assign irq_o             = |(s_q.irq_sts & s_q.irq_en);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_zero_spd;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.func == FC_ZERO_SPD && !running_i) ##1 (s_q.func == FC_ZERO_SPD) |=> term_o;
   endproperty
   a_zero_spd: assert property (p_zero_spd) else $error("zero speed not on when stopped");

   property p_pon;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.func == FC_PON_TIME && pon_time_i > s_q.pon_thr) ##1 (s_q.func == FC_PON_TIME)
      |=> term_o;
   endproperty
   a_pon: assert property (p_pon) else $error("power-on time output missing");

   property p_timing;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.func == FC_TIMING && !s_q.tmr_en) ##1 (s_q.func == FC_TIMING && !s_q.tmr_en)
      |=> !term_o;
   endproperty
   a_timing: assert property (p_timing) else $error("timing output while disabled");

   property p_ain;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.func == FC_AIN_LIM && analog_input_one_i > s_q.ain_hi)
      ##1 (s_q.func == FC_AIN_LIM) |=> term_o;
   endproperty
   a_ain: assert property (p_ain) else $error("analog limit output missing");

   property p_load;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.func == FC_LOAD_LOSS)[*3] |-> (term_o == $past(load_loss_i, 2));
   endproperty
   a_load: assert property (p_load) else $error("load loss output wrong");

   property p_rev;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.func == FC_REVERSE)[*3] |-> (term_o == $past(running_i && reverse_i, 2));
   endproperty
   a_rev: assert property (p_rev) else $error("reverse output wrong");

   property p_temp;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.func == FC_MOD_TEMP)[*3] |-> (term_o == $past(heatsink_temp_i >= s_q.temp_thr, 2));
   endproperty
   a_temp: assert property (p_temp) else $error("temperature output wrong");

   property p_warn;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.func == FC_WARNING)[*3] |-> (term_o == $past(fault_i && fault_continue_i, 2));
   endproperty
   a_warn: assert property (p_warn) else $error("warning output wrong");

   property p_low_lim;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.func == FC_LOW_LIM && !running_i) ##1 (s_q.func == FC_LOW_LIM)
      |=> term_o;
   endproperty
   a_low_lim: assert property (p_low_lim) else $error("lower limit output missing");

   property p_run_time;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.func == FC_RUN_TIME && run_time_i > s_q.run_thr) ##1 (s_q.func == FC_RUN_TIME)
      |=> term_o;
   endproperty
   a_run_time: assert property (p_run_time) else $error("run time output missing");

   property p_timing_on;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.func == FC_TIMING && s_q.tmr_en && run_time_i >= s_q.tmr_set)
      ##1 (s_q.func == FC_TIMING) |=> term_o;
   endproperty
   a_timing_on: assert property (p_timing_on) else $error("timer output missing");

   property p_ctrl_wr;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.st == OTSS_ACK && avs_write_i && avs_address_i == REG_CTRL)
      |=> (s_q.host_val == $past(avs_writedata_i[CTRL_HOST_BIT]));
   endproperty
   a_ctrl_wr: assert property (p_ctrl_wr) else $error("host value not stored");

   // Bus and interrupt checks
   property p_bus_answer;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.st == OTSS_IDLE && (avs_read_i || avs_write_i))
      |=> !avs_waitrequest_o;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("request not answered");

   property p_bus_stand;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      !avs_waitrequest_o
      |=> avs_waitrequest_o;
   endproperty
   a_bus_stand: assert property (p_bus_stand) else $error("waitrequest low too long");

   property p_rdata_zero;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      avs_waitrequest_o
      |-> (avs_readdata_o == '0);
   endproperty
   a_rdata_zero: assert property (p_rdata_zero) else $error("read data not zero when idle");

   property p_rd_status;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.st == OTSS_IDLE && avs_read_i && avs_address_i == REG_STATUS)
      |=> (avs_readdata_o[STS_OUT_BIT] == $past(term));
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("status read wrong");

   property p_wr_func;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.st == OTSS_ACK && avs_write_i && avs_address_i == REG_FUNC)
      |=> (s_q.func == $past(avs_writedata_i[FUNC_W-1:0]));
   endproperty
   a_wr_func: assert property (p_wr_func) else $error("function code not stored");

   property p_irq_rise;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (term && !s_q.term_prev)
      |=> s_q.irq_sts[IRQ_RISE_BIT];
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("rising event not latched");

   property p_irq_fall;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (!term && s_q.term_prev)
      |=> s_q.irq_sts[IRQ_FALL_BIT];
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("falling event not latched");

   property p_irq_clr;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (s_q.st == OTSS_ACK && avs_write_i && avs_address_i == REG_IRQ_CLR
       && avs_writedata_i[IRQ_RISE_BIT] && !(term && !s_q.term_prev))
      |=> !s_q.irq_sts[IRQ_RISE_BIT];
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("rising event not cleared");
endmodule
`default_nettype wire

// File: otss_relay_model.sv
// Partner model: relay coil or controller input wired to the terminal
`default_nettype none
module otss_relay_model
(
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic resetn_i,
   // Coil drive from the terminal
   input  wire logic coil_i,
   // Contact state seen by the outside controller
   output logic      contact_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Contact follows the coil one clock later; open while in reset
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         contact_o <= 1'b0;
      else
         contact_o <= coil_i;
   end
endmodule
`default_nettype wire

// File: output_terminal_status_select_bench.sv
// Self-checking bench for the output terminal status selector
`default_nettype none
module output_terminal_status_select_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import otss_pkg::*;
   logic              sys_clk_i = 1'b0;
   logic              resetn_i = 1'b0;
   logic [ADDR_W-1:0] adr = '0;
   logic              rd = 1'b0, wr = 1'b0, smp = 1'b0;
   logic [31:0]       wdat = '0, pon = '0, rtm = '0, thr, rdat;
   logic [15:0]       freq = '0, low = '0, ain = '0, temp = '0, lo, hi;
   logic              run = 1'b0, rev = 1'b0, ll = 1'b0, flt = 1'b0, fcont = 1'b0;
   logic              waitreq, term, irq, contact;
   int                errors = 0;
   int                samples_checked = 0;
   integer            seed = 10686;
   logic [31:0]       rq[$];
   logic [1:0]        tq[$];
   logic [FUNC_W-1:0] resv[3] = '{6'd21, 6'd22, 6'd39};

   otss_top #(.VAL_W(16)) otss_top_i (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq),
      .out_freq_i(freq), .low_lim_freq_i(low), .running_i(run), .reverse_i(rev),
      .load_loss_i(ll), .fault_i(flt), .fault_continue_i(fcont),
      .pon_time_i(pon), .run_time_i(rtm), .analog_input_one_i(ain),
      .heatsink_temp_i(temp), .term_o(term), .irq_o(irq));
   otss_relay_model otss_relay_model_i (
      .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .coil_i(term), .contact_o(contact));

   initial
   begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %0t read exp %h got %h", $time, e, g);
      end
   endtask
   task automatic cmp_term(input logic [1:0] e, input logic [1:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("[FAIL] %0t irq,term exp %h got %h", $time, e, g);
      end
   endtask
   // Results are compared in the order their notes were queued
   always @(posedge sys_clk_i)
   begin
      if (rd && waitreq === 1'b0)
         cmp_rd(rq.pop_front(), rdat);
      if (smp)
         cmp_term(tq.pop_front(), {irq, contact});
   end
   ////////////////////////////////////////////////////////////////////////////
   // One Avalon access: held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= d;
      // Only the watchdog ends a wait that never gets its answer
      do
         @(posedge sys_clk_i);
      while (waitreq !== 1'b0);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wreg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(1'b0, a, '0);
   endtask
   task automatic sel(input logic [FUNC_W-1:0] f);
      wreg(REG_FUNC, 32'(f));
   endtask
   // Let inputs settle, then sample contact, irq and the status register
   task automatic chk(input logic e, input logic ei = 1'b0);
      repeat (5) @(posedge sys_clk_i);
      tq.push_back({ei, e});
      smp <= 1'b1;
      @(posedge sys_clk_i);
      smp <= 1'b0;
      rdchk(REG_STATUS, {31'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #(25 * 20000);
      errors++;
      finish_test();
   end
   initial
   begin
      repeat (20) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      rdchk(REG_FUNC, ZERO32);
      rdchk(REG_IRQ_EN, ZERO32);
      wreg(4'hF, 32'hFFFF_FFFF);
      rdchk(4'hF, ZERO32);
      run <= 1'b1;
      chk(1'b0);
      $display("test reset done");
      sel(FC_ZERO_SPD);
      chk(1'b1);
      freq <= 16'h0005;
      chk(1'b0);
      run <= 1'b0;
      chk(1'b1);
      $display("test zero speed done");
      thr = ($random(seed) & 32'h0FFF_FFFF) | 32'h0000_0100;
      wreg(REG_PON_THR, thr);
      rdchk(REG_PON_THR, thr);
      sel(FC_PON_TIME);
      pon <= thr;
      chk(1'b0);
      pon <= thr + 32'h1;
      chk(1'b1);
      wreg(REG_TMR_SET, thr);
      wreg(REG_CTRL, ZERO32);
      sel(FC_TIMING);
      rtm <= thr;
      chk(1'b0);
      wreg(REG_CTRL, 32'h2);
      rdchk(REG_CTRL, 32'h2);
      chk(1'b1);
      rtm <= thr - 32'h1;
      chk(1'b0);
      wreg(REG_RUN_THR, thr);
      rdchk(REG_RUN_THR, thr);
      sel(FC_RUN_TIME);
      rtm <= thr;
      chk(1'b0);
      rtm <= thr + 32'h1;
      chk(1'b1);
      $display("test time limits done");
      lo = {1'b0, thr[14:0]} + 16'h1;
      hi = lo + 16'd100;
      wreg(REG_AIN_LIM, {hi, lo});
      rdchk(REG_AIN_LIM, {hi, lo});
      sel(FC_AIN_LIM);
      ain <= lo;
      chk(1'b0);
      ain <= lo - 16'h1;
      chk(1'b1);
      ain <= hi;
      chk(1'b0);
      ain <= hi + 16'h1;
      chk(1'b1);
      wreg(REG_TEMP_THR, {16'h0, hi});
      rdchk(REG_TEMP_THR, {16'h0, hi});
      sel(FC_MOD_TEMP);
      temp <= hi;
      chk(1'b1);
      temp <= lo;
      chk(1'b0);
      $display("test analog levels done");
      sel(FC_LOAD_LOSS);
      ll <= 1'b1;
      chk(1'b1);
      ll <= 1'b0;
      chk(1'b0);
      sel(FC_REVERSE);
      run <= 1'b1;
      rev <= 1'b1;
      chk(1'b1);
      rev <= 1'b0;
      chk(1'b0);
      sel(FC_LOW_LIM);
      low <= 16'h0100;
      freq <= 16'h0100;
      chk(1'b1);
      freq <= 16'h0101;
      chk(1'b0);
      run <= 1'b0;
      chk(1'b1);
      sel(FC_WARNING);
      flt <= 1'b1;
      chk(1'b0);
      fcont <= 1'b1;
      chk(1'b1);
      flt <= 1'b0;
      chk(1'b0);
      $display("test drive states done");
      ll <= 1'b1;
      rev <= 1'b1;
      flt <= 1'b1;
      wreg(REG_CTRL, 32'h3);
      foreach (resv[i])
      begin
         sel(resv[i]);
         chk(1'b0);
      end
      sel(FC_HOST);
      chk(1'b1);
      wreg(REG_CTRL, ZERO32);
      chk(1'b0);
      $display("test host and reserved done");
      wreg(REG_IRQ_CLR, 32'h3);
      wreg(REG_IRQ_EN, 32'h1);
      wreg(REG_CTRL, 32'h1);
      chk(1'b1, 1'b1);
      rdchk(REG_IRQ_STS, 32'h1);
      wreg(REG_IRQ_EN, ZERO32);
      chk(1'b1, 1'b0);
      wreg(REG_IRQ_EN, 32'h1);
      wreg(REG_IRQ_CLR, 32'h1);
      chk(1'b1, 1'b0);
      wreg(REG_CTRL, ZERO32);
      chk(1'b0, 1'b0);
      rdchk(REG_IRQ_STS, 32'h2);
      wreg(REG_IRQ_EN, 32'h2);
      chk(1'b0, 1'b1);
      wreg(REG_IRQ_CLR, 32'h3);
      chk(1'b0, 1'b0);
      $display("test interrupts done");
      finish_test();
   end
endmodule
`default_nettype wire
